/* design/pxbc_top.sv */
// blink phase, port direction, device configuration and ninth pin control
`timescale 1ns/1ps
module pxbc_top (
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // register access
   input wire pxbc_pkg::pxbc_req_s reg_req,
   output logic [7:0] reg_rdata,
   // eight open-drain ports
   input wire logic [7:0] port_in,
   output logic [7:0] port_out,
   output logic [7:0] port_oe,
   // ninth pin, open drain
   output logic ninth_pin_out,
   output logic ninth_pin_oe,
   // intensity sourcing to the pwm stage
   input wire logic [31:0] port_intensity_in,
   output logic [31:0] port_intensity,
   output logic [3:0] ninth_pin_intensity
);
   logic [7:0] phase0;
   logic [7:0] phase1;
   logic [7:0] dir;
   logic [7:0] master;
   logic [5:0] cfg;
   logic [7:0] ref_level;
   pxbc_pkg::pxbc_state_e state;
   logic change_now;
   logic sel_phase1;
   logic [7:0] active_byte;
   logic [5:0] next_cfg;
   logic [7:0] next_ref_level;
   pxbc_pkg::pxbc_state_e next_state;
   logic [7:0] next_reg_rdata;
   logic [7:0] next_port_oe;
   logic next_ninth_pin_oe;
   logic [31:0] next_port_intensity;
   logic [3:0] next_ninth_pin_intensity;

   // ==========================================
   // plain byte registers
   pxbc_byte_reg #(.ADDR(pxbc_pkg::ADDR_PHASE0), .RESET_VAL(pxbc_pkg::RST_PHASE0)) u_phase0 (
      .clk(clk), .reset(reset), .ce(ce), .req(reg_req), .q(phase0));
   pxbc_byte_reg #(.ADDR(pxbc_pkg::ADDR_PHASE1), .RESET_VAL(pxbc_pkg::RST_PHASE1)) u_phase1 (
      .clk(clk), .reset(reset), .ce(ce), .req(reg_req), .q(phase1));
   pxbc_byte_reg #(.ADDR(pxbc_pkg::ADDR_DIR), .RESET_VAL(pxbc_pkg::RST_DIR)) u_dir (
      .clk(clk), .reset(reset), .ce(ce), .req(reg_req), .q(dir));
   pxbc_byte_reg #(.ADDR(pxbc_pkg::ADDR_MASTER), .RESET_VAL(pxbc_pkg::RST_MASTER)) u_master (
      .clk(clk), .reset(reset), .ce(ce), .req(reg_req), .q(master));

   // ==========================================
   // configuration and change reference
   // only input ports take part; a port turned input may flag a false change
   assign change_now = (state == pxbc_pkg::ST_RUN) && (|((port_in ^ ref_level) & dir));
   assign sel_phase1 = cfg[pxbc_pkg::BIT_BLINK_EN] & cfg[pxbc_pkg::BIT_FLIP];
   assign active_byte = sel_phase1 ? phase1 : phase0;

   always_comb begin
      next_cfg = cfg;
      next_ref_level = ref_level;
      next_state = state;
      case (state)
         pxbc_pkg::ST_INIT: begin
            // reference is sampled just after reset so a quiet bus raises no flag
            next_ref_level = port_in;
            next_state = pxbc_pkg::ST_RUN;
         end
         pxbc_pkg::ST_RUN: begin
            if (reg_req.wr && reg_req.addr == pxbc_pkg::ADDR_CONFIG) begin
               next_ref_level = port_in;
            end else if (reg_req.rd && reg_req.addr == pxbc_pkg::ADDR_INPUT) begin
               next_ref_level = port_in;
            end
         end
         default: begin
            next_state = pxbc_pkg::ST_INIT;
         end
      endcase
      if (reg_req.wr && reg_req.addr == pxbc_pkg::ADDR_CONFIG) begin
         // status bit 7 and bit 6 are not stored, writes to them are dropped
         next_cfg = reg_req.wdata[pxbc_pkg::CFG_STORED_W-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cfg <= pxbc_pkg::RST_CONFIG;
         ref_level <= 8'h00;
         state <= pxbc_pkg::ST_INIT;
      end else if (ce) begin
         cfg <= next_cfg;
         ref_level <= next_ref_level;
         state <= next_state;
      end
   end

   // ==========================================
   // read data
   always_comb begin
      next_reg_rdata = reg_rdata;
      if (reg_req.rd) begin
         case (reg_req.addr)
            pxbc_pkg::ADDR_INPUT: next_reg_rdata = port_in;
            pxbc_pkg::ADDR_PHASE0: next_reg_rdata = phase0;
            pxbc_pkg::ADDR_DIR: next_reg_rdata = dir;
            pxbc_pkg::ADDR_PHASE1: next_reg_rdata = phase1;
            pxbc_pkg::ADDR_MASTER: next_reg_rdata = master;
            pxbc_pkg::ADDR_CONFIG: next_reg_rdata = {change_now, 1'b0, cfg};
            default: next_reg_rdata = 8'h00;
         endcase
      end
   end

   // ==========================================
   // pin drive and intensity selection
   always_comb begin
      // oe high means the pin is pulled low; inputs are always released
      next_port_oe = ~dir & ~active_byte;
      if (cfg[pxbc_pkg::BIT_INT_EN]) begin
         next_ninth_pin_oe = change_now;
      end else if (sel_phase1) begin
         next_ninth_pin_oe = ~cfg[pxbc_pkg::BIT_AUX1];
      end else begin
         next_ninth_pin_oe = ~cfg[pxbc_pkg::BIT_AUX0];
      end
      for (int i = 0; i < pxbc_pkg::NUM_PORTS; i++) begin
         if (cfg[pxbc_pkg::BIT_GLOBAL]) begin
            next_port_intensity[i*4 +: 4] = master[3:0];
         end else begin
            next_port_intensity[i*4 +: 4] = port_intensity_in[i*4 +: 4];
         end
      end
      next_ninth_pin_intensity = cfg[pxbc_pkg::BIT_GLOBAL] ? master[3:0] : master[7:4];
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
         port_out <= 8'h00;
         port_oe <= 8'h00;
         ninth_pin_out <= 1'b0;
         ninth_pin_oe <= 1'b0;
         port_intensity <= 32'h0;
         ninth_pin_intensity <= 4'h0;
      end else if (ce) begin
         reg_rdata <= next_reg_rdata;
         port_out <= 8'h00;
         port_oe <= next_port_oe;
         ninth_pin_out <= 1'b0;
         ninth_pin_oe <= next_ninth_pin_oe;
         port_intensity <= next_port_intensity;
         ninth_pin_intensity <= next_ninth_pin_intensity;
      end
   end

   // ==========================================
   // assertions
   property p_blink_enable;
      @(posedge clk) disable iff (reset)
      ce && cfg[0] && cfg[1] |=> port_oe == (~$past(dir) & ~$past(phase1));
   endproperty
   a_blink_enable: assert property (p_blink_enable) else $error("blink on, flip set: phase 1 not used");

   property p_flip_phase0;
      @(posedge clk) disable iff (reset)
      ce && cfg[0] && !cfg[1] |=> port_oe == (~$past(dir) & ~$past(phase0));
   endproperty
   a_flip_phase0: assert property (p_flip_phase0) else $error("blink on, flip clear: phase 0 not used");

   property p_blink_off;
      @(posedge clk) disable iff (reset)
      ce && !cfg[0] |=> port_oe == (~$past(dir) & ~$past(phase0));
   endproperty
   a_blink_off: assert property (p_blink_off) else $error("blink off: ports not from phase 0");

   property p_phase_bit_level;
      @(posedge clk) disable iff (reset)
      ce && (dir == 8'h00) && !cfg[0] |=> port_oe == ~$past(phase0);
   endproperty
   a_phase_bit_level: assert property (p_phase_bit_level) else $error("phase bit polarity wrong");

   property p_input_released;
      @(posedge clk) disable iff (reset)
      ce |=> (port_oe & $past(dir)) == 8'h00;
   endproperty
   a_input_released: assert property (p_input_released) else $error("input port driven low");

   property p_individual;
      @(posedge clk) disable iff (reset)
      ce && !cfg[2] |=> port_intensity == $past(port_intensity_in) && ninth_pin_intensity == $past(master[7:4]);
   endproperty
   a_individual: assert property (p_individual) else $error("individual intensity not applied");

   property p_global;
      @(posedge clk) disable iff (reset)
      ce && cfg[2] |=> port_intensity == {8{$past(master[3:0])}} && ninth_pin_intensity == $past(master[3:0]);
   endproperty
   a_global: assert property (p_global) else $error("global intensity not applied");

   property p_int_pin;
      @(posedge clk) disable iff (reset)
      ce && cfg[3] |=> ninth_pin_oe == $past(change_now);
   endproperty
   a_int_pin: assert property (p_int_pin) else $error("ninth pin does not follow change");

   property p_gpo_pin;
      @(posedge clk) disable iff (reset)
      ce && !cfg[3] |=> ninth_pin_oe == !(($past(cfg[0]) && $past(cfg[1])) ? $past(cfg[5]) : $past(cfg[4]));
   endproperty
   a_gpo_pin: assert property (p_gpo_pin) else $error("ninth pin general output level wrong");

   property p_gpo_static;
      @(posedge clk) disable iff (reset)
      ce && !cfg[3] && !cfg[0] && cfg[4] |=> !ninth_pin_oe;
   endproperty
   a_gpo_static: assert property (p_gpo_static) else $error("ninth pin not released with bit 4 set");

   property p_gpo_phase1;
      @(posedge clk) disable iff (reset)
      ce && !cfg[3] && cfg[0] && cfg[1] && !cfg[5] |=> ninth_pin_oe;
   endproperty
   a_gpo_phase1: assert property (p_gpo_phase1) else $error("ninth pin not low in phase 1");

   property p_status_read;
      @(posedge clk) disable iff (reset)
      ce && reg_req.rd && reg_req.addr == 8'h0F |=> reg_rdata[7] == $past(change_now) && reg_rdata[6] == 1'b0;
   endproperty
   a_status_read: assert property (p_status_read) else $error("config status readback wrong");

   property p_dir_read;
      @(posedge clk) disable iff (reset)
      ce && reg_req.rd && reg_req.addr == 8'h03 |=> reg_rdata == $past(dir);
   endproperty
   a_dir_read: assert property (p_dir_read) else $error("direction readback wrong");

   property p_ref_capture;
      @(posedge clk) disable iff (reset)
      ce && state == pxbc_pkg::ST_RUN && reg_req.wr && reg_req.addr == 8'h0F |=> ref_level == $past(port_in);
   endproperty
   a_ref_capture: assert property (p_ref_capture) else $error("config write did not capture ports");

   property p_no_input_drive;
      @(posedge clk) disable iff (reset)
      // a direction write can land right after the antecedent, so only the edge it governs is checked
      (ce && dir == 8'hFF) [*2] |=> port_oe == 8'h00;
   endproperty
   a_no_input_drive: assert property (p_no_input_drive) else $error("all-input ports still driven");
endmodule

/* design/pxbc_pkg.sv */
// package: register map, field positions, reset values and carrier types of the blink/config block
package pxbc_pkg;

   // ==========================================
   // register addresses
   localparam logic [7:0] ADDR_INPUT = 8'h00;
   localparam logic [7:0] ADDR_PHASE0 = 8'h01;
   localparam logic [7:0] ADDR_DIR = 8'h03;
   localparam logic [7:0] ADDR_PHASE1 = 8'h09;
   localparam logic [7:0] ADDR_MASTER = 8'h0E;
   localparam logic [7:0] ADDR_CONFIG = 8'h0F;

   // ==========================================
   // reset values
   localparam logic [7:0] RST_PHASE0 = 8'hFF;
   localparam logic [7:0] RST_DIR = 8'hFF;
   localparam logic [7:0] RST_PHASE1 = 8'hFF;
   localparam logic [7:0] RST_MASTER = 8'h0F;
   localparam logic [5:0] RST_CONFIG = 6'h0C;

   // ==========================================
   // device configuration fields, intensity width and port count
   localparam int BIT_BLINK_EN = 0;
   localparam int BIT_FLIP = 1;
   localparam int BIT_GLOBAL = 2;
   localparam int BIT_INT_EN = 3;
   localparam int BIT_AUX0 = 4;
   localparam int BIT_AUX1 = 5;
   localparam int CFG_STORED_W = 6;
   localparam int INTENSITY_W = 4;
   localparam int NUM_PORTS = 8;

   // ==========================================
   // carrier and state types
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pxbc_req_s;

   typedef enum logic [0:0] {
      ST_INIT = 1'b0,
      ST_RUN = 1'b1
   } pxbc_state_e;

endpackage

/* design/pxbc_byte_reg.sv */
// one writable byte register with its own address and reset value
`timescale 1ns/1ps
module pxbc_byte_reg #(
   parameter logic [7:0] ADDR = 8'h00,
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // write access
   input wire pxbc_pkg::pxbc_req_s req,
   // stored value
   output logic [7:0] q
);
   logic [7:0] next_q;

   always_comb begin
      next_q = q;
      if (req.wr && req.addr == ADDR) begin
         next_q = req.wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= RESET_VAL;
      end else if (ce) begin
         q <= next_q;
      end
   end
endmodule

/* test/pxbc_pin_load.sv */
// pin load model: pull-ups and an external source on the eight ports
`timescale 1ns/1ps
module pxbc_pin_load (
   // device side
   input wire logic [7:0] port_oe,
   // external source level, one bit per port
   input wire logic [7:0] ext_level,
   output logic [7:0] port_in
);
   // ==========================================
   // wired level
   // a pulled-low port reads low whatever the source drives
   assign port_in = ext_level & ~port_oe;
endmodule

/* test/port_expander_blink_config_tb.sv */
// self-checking bench of the blink/config block
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module port_expander_blink_config_tb;
   // ==========================================
   // signals
   logic clk, reset, ce, rq, pq;
   pxbc_pkg::pxbc_req_s reg_req;
   logic [7:0] reg_rdata, port_in, port_out, port_oe, ext;
   logic ninth_pin_out, ninth_pin_oe;
   logic [31:0] intens, port_intensity;
   logic [3:0] ninth_pin_intensity;
   logic [7:0] c, d, a, b, m;
   logic [31:0] pi;
   logic [53:0] q[$];
   logic [53:0] e, g;
   int errors, checked, cycles;
   logic [7:0] ra[6] = '{8'h01, 8'h03, 8'h09, 8'h0E, 8'h0F, 8'h20};
   logic [7:0] rv[6] = '{8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'h0C, 8'h00};

   pxbc_top dut_u (.clk(clk), .reset(reset), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
      .port_in(port_in), .port_out(port_out), .port_oe(port_oe), .ninth_pin_out(ninth_pin_out),
      .ninth_pin_oe(ninth_pin_oe), .port_intensity_in(intens), .port_intensity(port_intensity),
      .ninth_pin_intensity(ninth_pin_intensity));
   pxbc_pin_load load_u (.port_oe(port_oe), .ext_level(ext), .port_in(port_in));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ==========================================
   // drivers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      @(posedge clk);
      reg_req <= '{1'b1, 1'b0, ad, dt};
      @(posedge clk);
      reg_req <= '0;
   endtask
   task automatic rd(input logic [7:0] ad, input logic [7:0] ex);
      @(posedge clk);
      q.push_back({46'h0, ex});
      reg_req <= '{1'b0, 1'b1, ad, 8'h00};
      @(posedge clk);
      reg_req <= '0;
   endtask
   task automatic pin(input logic [53:0] ex);
      @(posedge clk);
      q.push_back(ex);
      pq <= 1'b1;
      @(posedge clk);
      pq <= 1'b0;
   endtask
   // expected pin snapshot from the shadow copies of the registers
   // open drain: the data outputs themselves must always stay low
   function automatic logic [53:0] pe(input logic chg);
      logic [7:0] s;
      s = (c[0] && c[1]) ? b : a;
      return {9'h000, c[2] ? m[3:0] : m[7:4], c[2] ? {8{m[3:0]}} : pi,
         c[3] ? chg : ~((c[0] && c[1]) ? c[5] : c[4]), ~d & ~s};
   endfunction

   // ==========================================
   // monitor: oldest note against what the outputs show
   always @(posedge clk) rq <= reg_req.rd;
   always @(negedge clk) begin
      if (rq || pq) begin
         e = q.pop_front();
         g = rq ? {46'h0, reg_rdata} : {port_out, ninth_pin_out, ninth_pin_intensity, port_intensity,
            ninth_pin_oe, port_oe};
         `CHK(g, e)
      end
   end

   task automatic results();
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // a hang is cut short well beyond the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         results();
      end
   end

   // ==========================================
   // main sequence
   initial begin
      reset = 1'b1;
      ce = 1'b1;
      reg_req = '0;
      ext = 8'hFF;
      intens = 32'h0;
      rq = 1'b0;
      pq = 1'b0;
      errors = 0;
      checked = 0;
      cycles = 0;
      c = 8'h0C;
      d = 8'hFF;
      a = 8'hFF;
      b = 8'hFF;
      m = 8'h0F;
      pi = 32'h0;
      void'($urandom(32'ha24bcb01));
      cyc(12);
      reset <= 1'b0;
      cyc(3);
      for (int i = 0; i < 6; i++) rd(ra[i], rv[i]);
      pin(pe(1'b0));
      for (int i = 0; i < 12; i++) begin
         d = $urandom;
         a = $urandom;
         b = $urandom;
         m = $urandom;
         pi = $urandom;
         c = $urandom;
         c[3] = 1'b0;
         c[1:0] = i[1:0];
         @(posedge clk);
         intens <= pi;
         wr(pxbc_pkg::ADDR_DIR, d);
         wr(pxbc_pkg::ADDR_PHASE0, a);
         wr(pxbc_pkg::ADDR_PHASE1, b);
         wr(pxbc_pkg::ADDR_MASTER, m);
         wr(pxbc_pkg::ADDR_CONFIG, c);
         cyc(3);
         pin(pe(1'b0));
         rd(pxbc_pkg::ADDR_CONFIG, {2'b00, c[5:0]});
         rd(pxbc_pkg::ADDR_DIR, d);
      end
      // writes offered while the clock enable is low must leave every register untouched
      ce <= 1'b0;
      wr(pxbc_pkg::ADDR_DIR, ~d);
      wr(pxbc_pkg::ADDR_CONFIG, c ^ 8'h24);
      ce <= 1'b1;
      pin(pe(1'b0));
      d = 8'hFF;
      c = 8'h08;
      wr(pxbc_pkg::ADDR_DIR, d);
      wr(pxbc_pkg::ADDR_CONFIG, c);
      cyc(3);
      ext <= 8'hF7;
      cyc(4);
      pin(pe(1'b1));
      rd(pxbc_pkg::ADDR_CONFIG, 8'h88);
      ext <= 8'hFF;
      cyc(4);
      pin(pe(1'b0));
      rd(pxbc_pkg::ADDR_CONFIG, 8'h08);
      ext <= 8'hDF;
      cyc(4);
      rd(pxbc_pkg::ADDR_CONFIG, 8'h88);
      wr(pxbc_pkg::ADDR_CONFIG, c);
      cyc(3);
      pin(pe(1'b0));
      rd(pxbc_pkg::ADDR_CONFIG, 8'h08);
      // reading the input byte also takes a fresh reference
      ext <= 8'hFF;
      cyc(4);
      rd(pxbc_pkg::ADDR_CONFIG, 8'h88);
      rd(pxbc_pkg::ADDR_INPUT, 8'hFF);
      rd(pxbc_pkg::ADDR_CONFIG, 8'h08);
      cyc(3);
      results();
   end
endmodule
